// *** design/pin_synchronizer.sv ***
module pin_synchronizer
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_s;

   sync_s st;
   sync_s next_st;

   always_comb
   begin
      next_st = st;
      next_st.first  = async_in;
      next_st.second = st.first;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         assign sync_out[i] = st.second[i];
      end
   endgenerate
endmodule

// *** design/supervisor_pkg.sv ***
// Notes on behaviour
// R1: reset pulse lasts 2.67 us per pF of reset delay capacitance.
// R2: basic watchdog timeout is 2.67 us per pF of period capacitance.
// R3: grounded watchdog period pin disables the watchdog completely.
// R4: range select low uses basic timeout; high multiplies it by 500.
// R5: host must toggle the kick input before timeout, else reset.
// R6: kick edge or range select change clears count and restarts timing.
// R7: count held cleared while reset asserted; counts again after release.
// R8: floating kick input disables watchdog, but only in extended mode.
// R9: on timeout, assert reset for the pulse time, then resume watching.
// R10: reset asserted while supply low input is high.
// R11: kick and range inputs synchronised; edges found against prior value.
package supervisor_pkg;
   localparam real  CLK_PERIOD_NS                = 40.0;
   localparam real  RESET_PULSE_US_PER_PF        = 2.67;
   localparam real  WATCHDOG_TIMEOUT_US_PER_PF   = 2.67;
   localparam real  RESET_DELAY_CAPACITANCE_PF   = 100.0;
   localparam real  WATCHDOG_PERIOD_CAPACITANCE_PF = 100.0;
   localparam real  RESET_PULSE_TIME_US =
      RESET_PULSE_US_PER_PF * RESET_DELAY_CAPACITANCE_PF;
   localparam real  WATCHDOG_TIMEOUT_TIME_US =
      WATCHDOG_TIMEOUT_US_PER_PF * WATCHDOG_PERIOD_CAPACITANCE_PF;
   // least time rounds up, longest time rounds down
   localparam int   RESET_PULSE_INT =
      int'($ceil(RESET_PULSE_TIME_US * 1000.0 / CLK_PERIOD_NS));
   localparam int   WATCHDOG_TIMEOUT_INT =
      int'($floor(WATCHDOG_TIMEOUT_TIME_US * 1000.0 / CLK_PERIOD_NS));
   localparam logic [31:0] RESET_PULSE_CYCLES      = 32'(RESET_PULSE_INT);
   localparam logic [31:0] WATCHDOG_TIMEOUT_CYCLES =
      32'(WATCHDOG_TIMEOUT_INT);
   localparam logic [31:0] EXTENDED_FACTOR         = 32'h0000_01F4;

   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_COUNT  = 8'h08;
   localparam int          CTRL_ENABLE_BIT      = 0;
   localparam int          STATUS_RESET_BIT     = 0;
   localparam int          STATUS_EXTENDED_BIT  = 1;
   localparam int          STATUS_DISABLED_BIT  = 2;
   localparam int          STATUS_TIMEOUT_BIT   = 3;
   localparam logic        CTRL_ENABLE_RESET    = 1'b1;
   localparam int          HTRANS_ACTIVE_BIT    = 1;

   typedef enum logic [1:0]
   {
      REG_CTRL   = 2'h0,
      REG_STATUS = 2'h1,
      REG_COUNT  = 2'h2,
      REG_NONE   = 2'h3
   } reg_index_e;

   typedef enum logic [1:0]
   {
      ST_RUN    = 2'h0,
      ST_PULSE  = 2'h1,
      ST_SUPPLY = 2'h3
   } wd_state_e;

   typedef struct packed
   {
      logic kick;
      logic kick_undriven;
      logic range_select;
      logic period_grounded;
      logic supply_low;
   } pin_in_s;
endpackage

// *** design/supervisor_watchdog_reset_timer.sv ***
// The address map and register access over AHB-Lite were left to the implementer.
module supervisor_watchdog_reset_timer
#(
   parameter logic [31:0] RESET_PULSE_CYCLES =
      supervisor_pkg::RESET_PULSE_CYCLES,
   parameter logic [31:0] WATCHDOG_TIMEOUT_CYCLES =
      supervisor_pkg::WATCHDOG_TIMEOUT_CYCLES
)
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire supervisor_pkg::pin_in_s pins,
   output logic                         supervisor_reset
);
   localparam logic [31:0] EXT_CYCLES =
      32'(WATCHDOG_TIMEOUT_CYCLES * supervisor_pkg::EXTENDED_FACTOR);

   typedef struct packed
   {
      supervisor_pkg::wd_state_e  state;
      logic                       kick_prev;
      logic                       range_prev;
      logic [31:0]                count;
      logic [31:0]                pulse_cnt;
      logic                       ctrl_enable;
      logic                       timeout_seen;
      logic                       dp_valid;
      logic                       dp_write;
      supervisor_pkg::reg_index_e dp_index;
      logic [31:0]                rdata;
      logic                       readyout;
      logic                       reset_out;
   } state_s;

   state_s                    st;
   state_s                    next_st;
   supervisor_pkg::pin_in_s   pin_s;
   logic                      kick_edge;
   logic                      range_change;
   logic                      disabled;
   logic [31:0]               limit;
   logic                      addr_ok;

   function automatic supervisor_pkg::reg_index_e reg_index
   (
      input logic [31:0] addr
   );
      if (addr[31:8] != 24'h00_0000)
      begin
         reg_index = supervisor_pkg::REG_NONE;
      end
      else if (addr[7:0] == supervisor_pkg::ADDR_CTRL)
      begin
         reg_index = supervisor_pkg::REG_CTRL;
      end
      else if (addr[7:0] == supervisor_pkg::ADDR_STATUS)
      begin
         reg_index = supervisor_pkg::REG_STATUS;
      end
      else if (addr[7:0] == supervisor_pkg::ADDR_COUNT)
      begin
         reg_index = supervisor_pkg::REG_COUNT;
      end
      else
      begin
         reg_index = supervisor_pkg::REG_NONE;
      end
   endfunction

   pin_synchronizer
   #(
      .WIDTH ($bits(supervisor_pkg::pin_in_s))
   )
   u_sync
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (pins),
      .sync_out (pin_s)
   ); // R11

   assign kick_edge    = pin_s.kick != st.kick_prev; // R11
   assign range_change = pin_s.range_select != st.range_prev; // R11
   assign disabled     = pin_s.period_grounded // R3
                       | !st.ctrl_enable
                       | (pin_s.range_select & pin_s.kick_undriven); // R8
   assign limit        = pin_s.range_select ? EXT_CYCLES // R4
                                            : WATCHDOG_TIMEOUT_CYCLES; // R2
   assign addr_ok      = hsel & htrans[supervisor_pkg::HTRANS_ACTIVE_BIT]
                       & hready;

   always_comb
   begin
      next_st = st;
      next_st.kick_prev  = pin_s.kick;
      next_st.range_prev = pin_s.range_select;
      next_st.readyout   = 1'b1;
      case (st.state)
         supervisor_pkg::ST_RUN:
         begin
            if (pin_s.supply_low)
            begin
               next_st.state = supervisor_pkg::ST_SUPPLY; // R10
               next_st.count = '0;
            end
            else if (disabled || kick_edge || range_change)
            begin
               next_st.count = '0; // R3 R6 R8
            end
            else if (st.count >= limit - 32'h0000_0001)
            begin
               next_st.state        = supervisor_pkg::ST_PULSE; // R5 R9
               next_st.count        = '0;
               next_st.pulse_cnt    = '0;
               next_st.timeout_seen = 1'b1;
            end
            else
            begin
               next_st.count = st.count + 32'h0000_0001;
            end
         end
         supervisor_pkg::ST_PULSE:
         begin
            next_st.count = '0; // R7
            if (pin_s.supply_low)
            begin
               next_st.state = supervisor_pkg::ST_SUPPLY; // R10
            end
            else if (st.pulse_cnt >= RESET_PULSE_CYCLES - 32'h0000_0001)
            begin
               next_st.state = supervisor_pkg::ST_RUN; // R1 R9
            end
            else
            begin
               next_st.pulse_cnt = st.pulse_cnt + 32'h0000_0001;
            end
         end
         default:
         begin
            next_st.count = '0; // R7
            if (!pin_s.supply_low)
            begin
               next_st.state     = supervisor_pkg::ST_PULSE; // R1
               next_st.pulse_cnt = '0;
            end
         end
      endcase
      next_st.reset_out = next_st.state != supervisor_pkg::ST_RUN;

      // data phase of a write
      if (st.dp_valid && st.dp_write)
      begin
         if (st.dp_index == supervisor_pkg::REG_CTRL)
         begin
            next_st.ctrl_enable = hwdata[supervisor_pkg::CTRL_ENABLE_BIT];
         end
         else if (st.dp_index == supervisor_pkg::REG_STATUS)
         begin
            // write one clears; a new timeout in this cycle wins
            if (hwdata[supervisor_pkg::STATUS_TIMEOUT_BIT]
                && !(st.state == supervisor_pkg::ST_RUN
                     && next_st.state == supervisor_pkg::ST_PULSE))
            begin
               next_st.timeout_seen = 1'b0;
            end
         end
      end

      // address phase
      next_st.dp_valid = addr_ok;
      next_st.dp_write = hwrite;
      next_st.dp_index = reg_index(haddr);
      next_st.rdata    = '0;
      if (addr_ok && !hwrite)
      begin
         if (reg_index(haddr) == supervisor_pkg::REG_CTRL)
         begin
            next_st.rdata[supervisor_pkg::CTRL_ENABLE_BIT] = st.ctrl_enable;
         end
         else if (reg_index(haddr) == supervisor_pkg::REG_STATUS)
         begin
            next_st.rdata[supervisor_pkg::STATUS_RESET_BIT]    = st.reset_out;
            next_st.rdata[supervisor_pkg::STATUS_EXTENDED_BIT] =
               pin_s.range_select;
            next_st.rdata[supervisor_pkg::STATUS_DISABLED_BIT] = disabled;
            next_st.rdata[supervisor_pkg::STATUS_TIMEOUT_BIT]  =
               st.timeout_seen;
         end
         else if (reg_index(haddr) == supervisor_pkg::REG_COUNT)
         begin
            next_st.rdata = st.count;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st             <= '0;
         st.state       <= supervisor_pkg::ST_PULSE;
         st.ctrl_enable <= supervisor_pkg::CTRL_ENABLE_RESET;
         st.readyout    <= 1'b1;
         st.reset_out   <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign hrdata           = st.rdata;
   assign hreadyout        = st.readyout;
   assign hresp            = 1'b0;
   assign supervisor_reset = st.reset_out;

   sequence seq_expire;
      st.state == supervisor_pkg::ST_RUN && !pin_s.supply_low && !disabled
      && !kick_edge && !range_change && st.count >= limit - 32'h0000_0001;
   endsequence

   sequence seq_pulse_end;
      st.state == supervisor_pkg::ST_PULSE && !pin_s.supply_low
      && st.pulse_cnt >= RESET_PULSE_CYCLES - 32'h0000_0001;
   endsequence

   AST_PULSE_END: assert property ( // R1
      @(posedge hclk) disable iff (!hresetn)
      seq_pulse_end |=> !supervisor_reset && st.count == 32'h0000_0000)
      else $error("reset pulse did not end at its length");

   AST_EXPIRE: assert property ( // R2
      @(posedge hclk) disable iff (!hresetn)
      seq_expire |=> supervisor_reset && st.pulse_cnt == 32'h0000_0000)
      else $error("timeout did not start a reset pulse");

   AST_GROUNDED: assert property ( // R3
      @(posedge hclk) disable iff (!hresetn)
      pin_s.period_grounded |=> !$rose(supervisor_reset)
                                || $past(pin_s.supply_low))
      else $error("watchdog reset while period pin grounded");

   AST_RANGE_LIMIT: assert property ( // R4
      @(posedge hclk) disable iff (!hresetn)
      st.state == supervisor_pkg::ST_RUN && pin_s.range_select
      |-> st.count < EXT_CYCLES)
      else $error("extended count passed its limit");

   AST_KICK_CLEAR: assert property ( // R6
      @(posedge hclk) disable iff (!hresetn)
      kick_edge || range_change |=> st.count == 32'h0000_0000)
      else $error("edge did not clear the watchdog count");

   AST_HELD_CLEAR: assert property ( // R7
      @(posedge hclk) disable iff (!hresetn)
      supervisor_reset |-> st.count == 32'h0000_0000)
      else $error("count moved while reset asserted");

   AST_FLOAT_EXT: assert property ( // R8
      @(posedge hclk) disable iff (!hresetn)
      pin_s.range_select && pin_s.kick_undriven
      |=> st.count == 32'h0000_0000)
      else $error("floating kick did not disable extended mode");

   AST_FLOAT_NORMAL: assert property ( // R8
      @(posedge hclk) disable iff (!hresetn)
      st.state == supervisor_pkg::ST_RUN && !pin_s.range_select
      && pin_s.kick_undriven && !pin_s.period_grounded && st.ctrl_enable
      && !kick_edge && !range_change && !pin_s.supply_low
      && st.count < limit - 32'h0000_0001
      |=> st.count == $past(st.count) + 32'h0000_0001)
      else $error("floating kick stopped normal mode");

   AST_SUPPLY: assert property ( // R10
      @(posedge hclk) disable iff (!hresetn)
      pin_s.supply_low |=> supervisor_reset)
      else $error("supply low without reset");

   AST_SYNC: assert property ( // R11
      @(posedge hclk) disable iff (!hresetn)
      1'b1 ##2 1'b1 |-> pin_s.kick == $past(pins.kick, 2))
      else $error("kick input not two flops deep");
endmodule

// *** tb/host_model.sv ***
module host_model
(
   input  wire logic hclk,
   input  wire logic cpu_reset,
   input  wire logic run,
   input  wire logic once,
   input  int        period,
   output logic      kick
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;

   initial kick = 1'b0;

   // processor in reset does not service the watchdog
   always @(posedge hclk)
   begin
      if (cpu_reset)
         cnt <= 0;
      else if (once || (run && cnt >= period - 1))
      begin
         kick <= ~kick;
         cnt  <= 0;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

// *** tb/supervisor_watchdog_reset_timer_tb.sv ***
module supervisor_watchdog_reset_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RP = 8;
   localparam int WD = 20;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        kick;
   logic        undrv = 1'b0;
   logic        range_sel = 1'b0;
   logic        gnd = 1'b0;
   logic        supply = 1'b0;
   logic        run = 1'b0;
   logic        once = 1'b0;
   logic        sreset;
   int          period = 10;
   int          fails = 0;
   int          num_checks = 0;
   int          seed = 32'h460F67DF;
   int          n;
   logic [31:0] r;
   supervisor_pkg::pin_in_s pins;

   assign pins = {kick, undrv, range_sel, gnd, supply};

   supervisor_watchdog_reset_timer
   #(
      .RESET_PULSE_CYCLES      (32'(RP)),
      .WATCHDOG_TIMEOUT_CYCLES (32'(WD))
   )
   u_dut
   (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .hsel             (hsel),
      .haddr            (haddr),
      .htrans           (htrans),
      .hwrite           (hwrite),
      .hsize            (3'h2),
      .hwdata           (hwdata),
      .hready           (hreadyout),
      .hrdata           (hrdata),
      .hreadyout        (hreadyout),
      .hresp            (hresp),
      .pins             (pins),
      .supervisor_reset (sreset)
   );

   host_model u_host
   (
      .hclk      (hclk),
      .cpu_reset (sreset),
      .run       (run),
      .once      (once),
      .period    (period),
      .kick      (kick)
   );

   initial forever #20 hclk = ~hclk;

   task results();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task check_eq(input string name, input logic [31:0] exp,
                 input logic [31:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task check_in(input string name, input int lo, input int hi,
                 input int seen);
      num_checks++;
      if (seen < lo || seen > hi)
      begin
         fails++;
         $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, seen);
      end
   endtask

   task wait_ready();
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         fails++;
         results();
      end
   endtask

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask

   task wait_rise(input int bound, output int cnt);
      cnt = 0;
      while (sreset !== 1'b1 && cnt < bound)
      begin
         @(posedge hclk);
         cnt++;
      end
   endtask

   task pulse_len(output int cnt);
      cnt = 0;
      while (sreset === 1'b1 && cnt < 20000)
      begin
         @(posedge hclk);
         cnt++;
      end
      if (cnt >= 20000)
      begin
         fails++;
         results();
      end
   endtask

   // expected limit from mode, then the pulse that follows
   task measure(input int lim);
      wait_rise(lim + 50, n);
      check_in("timeout", lim + 2, lim + 7, n);
      pulse_len(n);
      check_in("pulse", RP, RP + 1, n);
   endtask

   task quiet(input string name);
      wait_rise(100, n);
      check_in(name, 100, 100, n);
   endtask

   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      pulse_len(n);
      check_in("release pulse", RP - 1, RP + 1, n);
      period = 5 + ($unsigned($random(seed)) % 11);
      run <= 1'b1;
      ahb(1'b0, 32'h0000_0000, 32'h0000_0000, r);
      check_eq("ctrl reset", 32'h0000_0001, r);
      check_eq("hresp", 32'h0000_0000, {31'h0, hresp});
      wait_rise(300, n);
      check_in("kicked", 300, 300, n);
      run <= 1'b0;
      once <= 1'b1;
      @(posedge hclk);
      once <= 1'b0;
      measure(WD);
      run <= 1'b1;
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
      check_eq("status seen", 32'h0000_0008, r);
      ahb(1'b1, 32'h0000_0004, 32'h0000_0008, r);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
      check_eq("status clear", 32'h0000_0000, r);
      run <= 1'b0;
      range_sel <= 1'b1;
      measure(WD * 500);
      range_sel <= 1'b0;
      run <= 1'b1;
      @(posedge hclk);
      range_sel <= 1'b1;
      undrv <= 1'b1;
      run <= 1'b0;
      quiet("float ext");
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
      check_eq("status ext", 32'h0000_000E, r);
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000, r);
      check_eq("count held", 32'h0000_0000, r);
      range_sel <= 1'b0;
      measure(WD);
      undrv <= 1'b0;
      gnd <= 1'b1;
      run <= 1'b0;
      // let the pin pass the two sync flops first
      repeat (2) @(posedge hclk);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
      check_eq("disabled", 32'h0000_0004, r & 32'h0000_0004);
      quiet("grounded");
      gnd <= 1'b0;
      run <= 1'b1;
      ahb(1'b1, 32'h0000_0000, 32'h0000_0000, r);
      run <= 1'b0;
      quiet("ctrl off");
      ahb(1'b0, 32'h0000_0000, 32'h0000_0000, r);
      check_eq("ctrl off", 32'h0000_0000, r);
      run <= 1'b1;
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001, r);
      ahb(1'b1, 32'h0000_0010, $random(seed), r);
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000, r);
      check_eq("unmapped", 32'h0000_0000, r);
      supply <= 1'b1;
      repeat (4) @(posedge hclk);
      n = 0;
      repeat (26)
      begin
         @(posedge hclk);
         if (sreset === 1'b1)
            n++;
      end
      check_in("supply hold", 26, 26, n);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
      check_eq("status supply", 32'h0000_0009, r);
      supply <= 1'b0;
      pulse_len(n);
      check_in("supply end", RP, RP + 4, n);
      results();
   end
endmodule
